// ==== rtl/tis_pkg.sv ====
`default_nettype none
package tis_pkg;
    // 7-bit slave addresses; the write/read byte pairs are these shifted
    localparam logic [6:0] TIS_ADDR_PRI = 7'h5D;
    localparam logic [6:0] TIS_ADDR_ALT = 7'h14;
    // highest bus rate the port is specified for, bits per second
    localparam int TIS_BUS_MAX_BPS = 400000;
    // register map
    localparam logic [15:0] TIS_REG_CMD = 16'h8040;
    localparam logic [15:0] TIS_REG_CFG_REV = 16'h8047;
    localparam logic [15:0] TIS_REG_X_RES_LO = 16'h8048;
    localparam logic [15:0] TIS_REG_X_RES_HI = 16'h8049;
    localparam logic [15:0] TIS_REG_Y_RES_LO = 16'h804A;
    localparam logic [15:0] TIS_REG_Y_RES_HI = 16'h804B;
    localparam logic [15:0] TIS_REG_MAX_TOUCH = 16'h804C;
    localparam logic [15:0] TIS_REG_FEAT_ONE = 16'h804D;
    localparam int TIS_CFG_DEPTH = 7;
    localparam int TIS_CFG_AW = 3;
    // framing and reset values
    localparam logic [3:0] TIS_BYTE_BITS = 4'h8;
    localparam logic [1:0] TIS_STRAP_WAIT = 2'h3;
    localparam logic [7:0] TIS_READ_FILL = 8'h00;
    localparam logic [15:0] TIS_PTR_RESET = 16'h0000;

    typedef enum logic [5:0] {
        TIS_IDLE = 6'h01,
        TIS_ADDR = 6'h02,
        TIS_REG_HI = 6'h04,
        TIS_REG_LO = 6'h08,
        TIS_WDATA = 6'h10,
        TIS_RDATA = 6'h20
    } tis_state_t;

    // one register access handed from the link to the core clock
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } tis_xfer_t;

    // address selection caught after reset release
    typedef struct packed {
        logic valid;
        logic alt;
    } tis_strap_t;

    // true for the writable configuration block
    function automatic logic tis_cfg_hit(input logic [15:0] addr);
        return (addr >= TIS_REG_CFG_REV) && (addr <= TIS_REG_FEAT_ONE);
    endfunction

    function automatic logic [TIS_CFG_AW-1:0] tis_cfg_index(
        input logic [15:0] addr);
        logic [15:0] d;
        d = addr - TIS_REG_CFG_REV;
        return d[TIS_CFG_AW-1:0];
    endfunction
endpackage
`default_nettype wire

// ==== rtl/tis_regmem.sv ====
`default_nettype none
module tis_regmem #(
    parameter int DEPTH = 7,
    parameter int WIDTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // contents have no defined value until written
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // tis_regmem
`default_nettype wire

// ==== rtl/tis_sync.sv ====
`default_nettype none
module tis_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // two stages; the first is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // tis_sync
`default_nettype wire

// ==== rtl/tis_touch_i2c_slave.sv ====
// Contract
// - slave only; master starts every transfer; bus at most 400 kbit/s.
// - one of two address pairs, picked by master on reset/int at power-on.
// - data falling while clock high opens a transfer.
// - data rising while clock high closes the transfer.
// - matching 8-bit address word is acknowledged low on the ninth clock.
// - non-matching address gets no acknowledge; wait idle for next start.
// - every unit is eight data bits plus one acknowledge bit.
// - sender changes data only while clock low, stable while high.
// - pointer steps by one after every written data byte.
// - sequential read returns successive registers while master acks.
`default_nettype none
module tis_touch_i2c_slave
    import tis_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    input wire logic strap_int,
    output logic strap_valid,
    output logic addr_alt,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic cfg_wr_valid,
    output logic [TIS_CFG_AW-1:0] cfg_wr_index,
    output logic [7:0] cfg_wr_data
);
    // ---------------- link domain ----------------
    logic [4:0] lsync;
    logic scl_s, sda_s, scl_d, sda_d;
    tis_strap_t strap_l;
    logic ack_s;
    tis_state_t state;
    logic [3:0] bit_cnt;
    logic ack_phase, ack_own;
    logic [7:0] shreg, tx_sh, rx_data;
    logic [15:0] ptr;
    logic req_tog, ack_seen;
    tis_xfer_t xfer;
    tis_strap_t strap;
    logic [7:0] rdata_hold;
    logic ack_tog;

    tis_sync #(.WIDTH(5)) u_link_sync (
        .clk(link_clk),
        .rst_b(rst_b),
        .d({scl, sda_in, strap.valid, strap.alt, ack_tog}),
        .q(lsync)
    );
    assign scl_s = lsync[4];
    assign sda_s = lsync[3];
    assign strap_l = lsync[2:1];
    assign ack_s = lsync[0];

    // previous sampled pin levels for edge detection
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d <= 1'b0;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic start_cond, stop_cond, scl_rise, scl_fall, byte_done;
    logic addr_match, ack_now, pending;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s;
    assign stop_cond = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    // eight bits then the acknowledge slot
    assign byte_done = (bit_cnt == TIS_BYTE_BITS) && !ack_phase;
    // compare against the strapped pair only, once it is known
    assign addr_match = strap_l.valid &&
        (shreg[7:1] == (strap_l.alt ? TIS_ADDR_ALT : TIS_ADDR_PRI));
    // we acknowledge received bytes; in a read the master does
    assign ack_now = (state == TIS_ADDR) ? addr_match :
        ((state != TIS_RDATA) && (state != TIS_IDLE));
    // one access in flight at a time; a late one is dropped
    assign pending = req_tog != ack_seen;

    // protocol sequencer, pointer and access requests
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= TIS_IDLE;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            ack_own <= 1'b0;
            shreg <= 8'h00;
            ptr <= TIS_PTR_RESET;
            req_tog <= 1'b0;
            xfer <= '0;
        end else if (start_cond) begin
            // open, repeated start keeps the pointer
            state <= TIS_ADDR;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
        end else if (stop_cond) begin
            state <= TIS_IDLE;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
        end else if (state != TIS_IDLE) begin
            if (scl_rise && !ack_phase) begin
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_rise) begin
                bit_cnt <= 4'h0;
                if (state == TIS_RDATA && !ack_own) begin
                    if (sda_s) begin
                        state <= TIS_IDLE;
                    end else begin
                        // step and fetch the next register
                        ptr <= ptr + 16'h0001;
                        if (!pending) begin
                            xfer <= '{wr: 1'b0, addr: ptr + 16'h0001,
                                      data: 8'h00};
                            req_tog <= ~req_tog;
                        end
                    end
                end
            end else if (scl_fall && byte_done) begin
                ack_phase <= 1'b1;
                ack_own <= ack_now;
                case (state)
                    TIS_ADDR: begin
                        if (!addr_match) begin
                            state <= TIS_IDLE;
                        end else if (shreg[0]) begin
                            // read address, fetch at the pointer
                            state <= TIS_RDATA;
                            if (!pending) begin
                                xfer <= '{wr: 1'b0, addr: ptr,
                                          data: 8'h00};
                                req_tog <= ~req_tog;
                            end
                        end else begin
                            state <= TIS_REG_HI;
                        end
                    end
                    TIS_REG_HI: begin
                        ptr[15:8] <= shreg;
                        state <= TIS_REG_LO;
                    end
                    TIS_REG_LO: begin
                        ptr[7:0] <= shreg;
                        state <= TIS_WDATA;
                    end
                    TIS_WDATA: begin
                        ptr <= ptr + 16'h0001;
                        if (!pending) begin
                            xfer <= '{wr: 1'b1, addr: ptr, data: shreg};
                            req_tog <= ~req_tog;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end else if (scl_fall && ack_phase && bit_cnt == 4'h0) begin
                ack_phase <= 1'b0;
            end
        end
    end

    // read answers arrive with the toggle; data already stands
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_seen <= 1'b0;
            rx_data <= TIS_READ_FILL;
        end else if (ack_s != ack_seen) begin
            ack_seen <= ack_s;
            rx_data <= rdata_hold;
        end
    end

    // open-drain data drive; moves after a clock fall, released at start, stop or idle
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe_b <= 1'b1;
            sda_out <= 1'b0;
            tx_sh <= 8'h00;
        end else begin
            sda_out <= 1'b0;
            if (start_cond || stop_cond || state == TIS_IDLE) begin
                sda_oe_b <= 1'b1;
            end else if (scl_fall) begin
                // change only while the clock is low
                if (byte_done) begin
                    // acknowledge low during the ninth clock
                    sda_oe_b <= ~ack_now;
                end else if (ack_phase && state == TIS_RDATA) begin
                    sda_oe_b <= rx_data[7];
                    tx_sh <= {rx_data[6:0], 1'b0};
                end else if (ack_phase || state != TIS_RDATA) begin
                    sda_oe_b <= 1'b1;
                end else begin
                    sda_oe_b <= tx_sh[7];
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
            end
        end
    end

    // ---------------- core domain ----------------
    logic [1:0] msync;
    logic m_strap_s, m_req_s, m_req_seen, m_go, m_hit, m_done, m_rd_hit;
    logic [1:0] strap_cnt;
    logic [7:0] mem_q;

    tis_sync #(.WIDTH(2)) u_core_sync (
        .clk(mclk),
        .rst_b(rst_b),
        .d({strap_int, req_tog}),
        .q(msync)
    );
    assign m_strap_s = msync[1];
    assign m_req_s = msync[0];

    // catch the int level after release, once the sync has filled
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt <= 2'h0;
            strap <= '0;
        end else if (!strap.valid) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == TIS_STRAP_WAIT) begin
                strap <= '{valid: 1'b1, alt: m_strap_s};
            end
        end
    end
    assign strap_valid = strap.valid;
    assign addr_alt = strap.alt;

    // xfer is stable while its toggle is unanswered
    assign m_go = m_req_s != m_req_seen;
    assign m_hit = tis_cfg_hit(xfer.addr);

    tis_regmem #(
        .DEPTH(TIS_CFG_DEPTH),
        .WIDTH(8),
        .AW(TIS_CFG_AW)
    ) u_cfg_mem (
        .clk(mclk),
        .rst_b(rst_b),
        .we(m_go && xfer.wr && m_hit),
        .waddr(tis_cfg_index(xfer.addr)),
        .wdata(xfer.data),
        .raddr(tis_cfg_index(xfer.addr)),
        .rdata(mem_q)
    );

    // take the request, answer one cycle later with the read data
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            m_req_seen <= 1'b0;
            m_done <= 1'b0;
            m_rd_hit <= 1'b0;
            ack_tog <= 1'b0;
            rdata_hold <= TIS_READ_FILL;
        end else begin
            m_done <= m_go;
            if (m_go) begin
                m_req_seen <= m_req_s;
                m_rd_hit <= m_hit && !xfer.wr;
            end
            if (m_done) begin
                // command register is write-only and reads as fill
                rdata_hold <= m_rd_hit ? mem_q : TIS_READ_FILL;
                ack_tog <= ~ack_tog;
            end
        end
    end

    // strobes toward the touch engine
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_valid <= 1'b0;
            cmd_code <= 8'h00;
            cfg_wr_valid <= 1'b0;
            cfg_wr_index <= '0;
            cfg_wr_data <= 8'h00;
        end else begin
            cmd_valid <= m_go && xfer.wr && (xfer.addr == TIS_REG_CMD);
            cfg_wr_valid <= m_go && xfer.wr && m_hit;
            if (m_go && xfer.wr) begin
                cmd_code <= xfer.data;
                cfg_wr_index <= tis_cfg_index(xfer.addr);
                cfg_wr_data <= xfer.data;
            end
        end
    end

    // ---------------- checks ----------------
    sequence s_addr_byte;
        scl_fall && byte_done && state == TIS_ADDR;
    endsequence

    sequence s_master_ack;
        scl_rise && ack_phase && !ack_own && state == TIS_RDATA && !sda_s;
    endsequence

    a_start_opens: assert property (@(posedge link_clk) disable iff (!rst_b)
        start_cond |=> state == TIS_ADDR && bit_cnt == 4'h0)
        else $error("start did not open address phase");

    a_stop_closes: assert property (@(posedge link_clk) disable iff (!rst_b)
        stop_cond |=> state == TIS_IDLE && sda_oe_b)
        else $error("stop did not return to idle");

    a_addr_acked: assert property (@(posedge link_clk) disable iff (!rst_b)
        s_addr_byte and addr_match |=> !sda_oe_b && ack_phase)
        else $error("matching address not acknowledged");

    a_addr_ignored: assert property (@(posedge link_clk) disable iff (!rst_b)
        s_addr_byte and !addr_match |=> state == TIS_IDLE && sda_oe_b)
        else $error("foreign address was answered");

    a_nine_clocks: assert property (@(posedge link_clk) disable iff (!rst_b)
        scl_rise && ack_phase && state != TIS_IDLE |=> bit_cnt == 4'h0)
        else $error("unit did not end after the ninth clock");

    a_sda_high_hold: assert property (@(posedge link_clk) disable iff (!rst_b)
        scl_s && scl_d |->
            $stable(sda_oe_b) || $past(start_cond) || $past(stop_cond))
        else $error("data changed while clock high");

    a_write_step: assert property (@(posedge link_clk) disable iff (!rst_b)
        scl_fall && byte_done && state == TIS_WDATA |=>
            ptr == $past(ptr) + 16'h0001)
        else $error("pointer did not step after write");

    a_read_step: assert property (@(posedge link_clk) disable iff (!rst_b)
        s_master_ack |=> ptr == $past(ptr) + 16'h0001 ##1 state == TIS_RDATA)
        else $error("sequential read did not advance");

    a_reg_msb_first: assert property (@(posedge link_clk) disable iff (!rst_b)
        scl_fall && byte_done && state == TIS_REG_HI |=>
            ptr[15:8] == $past(shreg) && state == TIS_REG_LO)
        else $error("register address high byte misplaced");

    a_idle_silent: assert property (@(posedge link_clk) disable iff (!rst_b)
        state == TIS_IDLE && $past(state) == TIS_IDLE |-> sda_oe_b)
        else $error("data driven while not addressed");

    a_strap_fixed: assert property (@(posedge mclk) disable iff (!rst_b)
        strap.valid |=> $stable(strap))
        else $error("address selection changed after capture");
endmodule // tis_touch_i2c_slave
`default_nettype wire

// ==== testbench/tb.sv ====
`default_nettype none
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
end
module tb
    import tis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0;
    logic link_clk = 1'h0;
    logic rst_b = 1'h0;
    logic strap_int = 1'h0;
    wire logic scl;
    wire logic m_low;
    logic sda_out, sda_oe_b, strap_valid, addr_alt, cmd_valid, cfg_wr_valid;
    logic [7:0] cmd_code, cfg_wr_data;
    logic [TIS_CFG_AW-1:0] cfg_wr_index;
    int n_fail = 0;
    int checks_done = 0;
    logic [15:0] ptr;
    logic [7:0] ref_mem [logic [15:0]];
    logic [11:0] ev_exp [$];
    logic [11:0] ev_got [$];
    // open-drain data line with pull-up
    wire logic sda = (m_low || sda_oe_b === 1'h0) ? 1'h0 : 1'h1;

    always #12.5 mclk = ~mclk;
    // 6 ns period drifts against the 25 ns core clock
    always #3 link_clk = ~link_clk;

    tis_master m (.scl(scl), .sda_low(m_low), .sda(sda));
    tis_touch_i2c_slave uut (
        .mclk(mclk), .rst_b(rst_b), .link_clk(link_clk), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
        .strap_int(strap_int), .strap_valid(strap_valid),
        .addr_alt(addr_alt), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cfg_wr_valid(cfg_wr_valid), .cfg_wr_index(cfg_wr_index),
        .cfg_wr_data(cfg_wr_data)
    );

    // collect core-side strobes, each is one mclk wide
    always @(posedge mclk) begin
        if (cfg_wr_valid === 1'h1)
            ev_got.push_back({1'h0, cfg_wr_index, cfg_wr_data});
        if (cmd_valid === 1'h1)
            ev_got.push_back({1'h1, 3'h0, cmd_code});
    end

    // any drive change of the device must fall in a low clock phase
    always @(sda_oe_b) begin
        if (rst_b === 1'h1) begin
            `CHK("scl at data change", 1'h0, scl)
            // open drain: whenever the pin is driven it must be driven low
            if (sda_oe_b === 1'h0) begin
                `CHK("sda out", 1'h0, sda_out)
            end
        end
    end

    task automatic exp_wr(input logic [15:0] p, input logic [7:0] d);
        if (p == TIS_REG_CMD)
            ev_exp.push_back({1'h1, 3'h0, d});
        if (p >= TIS_REG_CFG_REV && p <= TIS_REG_FEAT_ONE) begin
            ref_mem[p] = d;
            ev_exp.push_back({1'h0, 3'(p - TIS_REG_CFG_REV), d});
        end
    endtask

    // unmapped places and the command register read back as zero
    function automatic logic [7:0] exp_rd(input logic [15:0] p);
        if (p >= TIS_REG_CFG_REV && p <= TIS_REG_FEAT_ONE)
            return ref_mem[p];
        return 8'h00;
    endfunction

    task automatic xfer(input logic [6:0] a, input logic [15:0] ra,
            input int nw, input int nr, input logic ack_exp);
        logic ack;
        logic [7:0] d;
        logic [11:0] e;
        logic [11:0] g;
        m.start();
        m.wbyte({a, 1'h0}, ack);
        `CHK("addr ack", ack_exp, ack)
        if (ack === 1'h1) begin
            m.wbyte(ra[15:8], ack);
            `CHK("reg hi ack", 1'h1, ack)
            m.wbyte(ra[7:0], ack);
            `CHK("reg lo ack", 1'h1, ack)
            ptr = ra;
            for (int i = 0; i < nw; i++) begin
                d = 8'($urandom);
                exp_wr(ptr, d);
                m.wbyte(d, ack);
                `CHK("data ack", 1'h1, ack)
                ptr++;
            end
            if (nr > 0) begin
                m.start();
                m.wbyte({a, 1'h1}, ack);
                `CHK("read addr ack", 1'h1, ack)
                for (int i = 0; i < nr; i++) begin
                    m.rbyte(i < nr - 1, d);
                    `CHK("read data", exp_rd(ptr), d)
                    ptr++;
                end
            end
        end
        m.stop();
        repeat (10) @(posedge mclk);
        `CHK("strobe count", ev_exp.size(), ev_got.size())
        while (ev_exp.size() > 0 && ev_got.size() > 0) begin
            e = ev_exp.pop_front();
            g = ev_got.pop_front();
            `CHK("core write", e, g)
        end
        ev_exp.delete();
        ev_got.delete();
        $display("test at %h done", ra);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        logic [6:0] a;
        void'($urandom(32'h9A81));
        repeat (16) @(posedge mclk);
        #2 rst_b = 1'h1;
        repeat (20) @(posedge mclk);
        `CHK("strap valid", 1'h1, strap_valid)
        `CHK("alt pair", 1'h0, addr_alt)
        // fill the whole config block, then command plus a dropped byte
        xfer(TIS_ADDR_PRI, TIS_REG_CFG_REV, 7, 0, 1'h1);
        xfer(TIS_ADDR_PRI, TIS_REG_CMD, 2, 0, 1'h1);
        // sequential read across both edges of the map
        xfer(TIS_ADDR_PRI, 16'h8046, 0, 9, 1'h1);
        // pointer survives the repeated start after a write
        xfer(TIS_ADDR_PRI, TIS_REG_MAX_TOUCH, 1, 2, 1'h1);
        xfer(TIS_ADDR_ALT, TIS_REG_CFG_REV, 1, 0, 1'h0);
        for (int k = 0; k < 3; k++) begin
            a = 7'($urandom);
            if (a == TIS_ADDR_PRI || a == TIS_ADDR_ALT)
                a ^= 7'h01;
            xfer(a, TIS_REG_CFG_REV, 1, 0, 1'h0);
            xfer(TIS_ADDR_PRI, TIS_REG_CMD + 16'($urandom_range(13)),
                $urandom_range(3, 1), $urandom_range(2), 1'h1);
        end
        // second reset with the strap picking the other pair
        @(posedge mclk);
        #2 rst_b = 1'h0;
        strap_int = 1'h1;
        repeat (4) @(posedge mclk);
        #2 rst_b = 1'h1;
        repeat (20) @(posedge mclk);
        `CHK("strap valid", 1'h1, strap_valid)
        `CHK("alt pair", 1'h1, addr_alt)
        xfer(TIS_ADDR_PRI, TIS_REG_CFG_REV, 1, 0, 1'h0);
        xfer(TIS_ADDR_ALT, TIS_REG_X_RES_LO, 2, 0, 1'h1);
        xfer(TIS_ADDR_ALT, TIS_REG_X_RES_LO, 0, 2, 1'h1);
        test_done();
    end

    // longest draw of the random tests is about 74k cycles
    initial begin
        repeat (90000) @(posedge mclk);
        n_fail++;
        test_done();
    end
endmodule // tb
`default_nettype wire

// ==== testbench/tis_master.sv ====
`default_nettype none
// bus master model; scl idles high and stands still between frames
module tis_master
    import tis_pkg::*;
(
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // quarter bit at the fastest rate the port allows, in ns
    localparam time TQ = 1000000000 / (4 * TIS_BUS_MAX_BPS);
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic start();
        sda_low = 1'h0;
        #TQ scl = 1'h1;
        #TQ sda_low = 1'h1;
        #TQ scl = 1'h0;
        #TQ;
    endtask
    task automatic stop();
        sda_low = 1'h1;
        #TQ scl = 1'h1;
        #TQ sda_low = 1'h0;
        #TQ;
    endtask
    // data set only while scl low
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #TQ scl = 1'h1;
        #TQ r = sda;
        #TQ scl = 1'h0;
        #TQ;
    endtask
    // eight bits msb first, then ack slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'h1, r);
        ack = ~r;
    endtask
    // ack every byte but the last
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, d[i]);
        end
        bit_io(~more, r);
    endtask
endmodule // tis_master
`default_nettype wire
